/* File: core/cpu8d_decoder.sv */
// opcode and operand decoder between program fetch and execution datapath
// assumes fetch offers bytes in program order with valid/ready, and the
// datapath supplies index, accumulator, next pc and branch condition
`timescale 1ns/10ps
module cpu8d_decoder
    import cpu8d_pkg::*;
(
    input  wire logic        core_clk,     // 200 MHz core clock
    input  wire logic        rst_b,        // async reset, active low
    input  wire logic        fetch_valid,  // fetch byte offered
    input  wire logic [7:0]  fetch_byte,   // program byte
    output logic             fetch_ready,  // decoder takes byte
    input  wire logic [7:0]  idx_val,      // index register
    input  wire logic [7:0]  acc_val,      // accumulator
    input  wire logic [15:0] pc_next,      // pc after this instruction
    input  wire logic        br_cond,      // branch condition true
    input  wire logic        irq_req,      // pending interrupt, core clock
    input  wire logic        ext_irq_b,    // external interrupt pin
    output cpu8d_dec_t       dec_q,        // decoded instruction
    output logic             dec_valid_q,  // one-cycle issue pulse
    output logic             pc_load_q,    // branch taken, load target
    output logic             acc_we_q,     // accumulator write
    output logic             idx_we_q,     // index write
    output logic [7:0]       wr_data_q,    // transfer data
    output logic             cpu_halt_q,   // cpu clock gated (wait or stop)
    output logic             osc_stop_q,   // oscillator stopped
    output logic             pin_wake_en_q // external pin armed as wake
);

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OPC, ST_OP1, ST_OP2, ST_EXEC, ST_HALT
    } cpu8d_state_t;

    cpu8d_state_t state_q, state_d;   // sequencer
    logic [7:0]   opc_q;              // opcode held
    logic [7:0]   b1_q;               // first operand byte
    logic [7:0]   b2_q;               // second operand byte
    logic         pin_s1_q, pin_s2_q; // external pin synchroniser
    logic         stop_q;             // halted by stop rather than wait

    // ------------------------------------------------------------------
    // column and operand-count decode of a byte
    // ------------------------------------------------------------------
    function automatic cpu8d_mode_t mode_of(input logic [7:0] op);
        cpu8d_mode_t m;
        m = implied_mode;
        case (op[7:4])
            4'h0:       m = bit_branch_mode;
            4'h1, 4'h3, 4'hB: m = direct_mode;
            4'h2:       m = relative_mode;
            4'h6, 4'hE: m = index_short_offset_mode;
            4'h7, 4'hF: m = index_plain_mode;
            4'hA:       m = (op == CPU8D_OPC_BSR) ? relative_mode
                                                   : literal_mode;
            4'hC:       m = full_address_mode;
            4'hD:       m = index_long_offset_mode;
            default:    m = implied_mode;
        endcase
        return m;
    endfunction : mode_of

    function automatic logic defined_op(input logic [7:0] op);
        logic [3:0] lo;
        logic       d;
        lo = op[3:0];
        d  = 1'b1;
        case (op[7:4]) // blank slots of the map
            4'h2:    d = (lo != 4'hE);
            4'h3, 4'h5, 4'h6, 4'h7:
                     d = !(lo == 4'h1 || lo == 4'h2 || lo == 4'h5 ||
                           lo == 4'hB || lo == 4'hE);
            4'h4:    d = !(lo == 4'h1 || lo == 4'h5 || lo == 4'hB ||
                           lo == 4'hE);
            4'h8:    d = (lo == 4'h0 || lo == 4'h1 || lo == 4'h3 ||
                          lo == 4'hE || lo == 4'hF);
            4'h9:    d = (lo >= 4'h7 && lo != 4'hE);
            4'hA:    d = !(lo == 4'h7 || lo == 4'hC || lo == 4'hF);
            default: d = 1'b1;
        endcase
        return d;
    endfunction : defined_op

    function automatic logic [1:0] nbytes(input cpu8d_mode_t m);
        logic [1:0] n;
        case (m)
            bit_branch_mode, full_address_mode,
            index_long_offset_mode:           n = 2'd2;
            direct_mode, relative_mode, literal_mode,
            index_short_offset_mode:          n = 2'd1;
            default:                          n = 2'd0;
        endcase
        return n;
    endfunction : nbytes

    // ------------------------------------------------------------------
    // combinational decode
    // ------------------------------------------------------------------
    wire         take      = fetch_valid && fetch_ready;
    wire         in_def    = defined_op(fetch_byte);
    wire [1:0]   in_need   = in_def ? nbytes(mode_of(fetch_byte)) : 2'd0;
    wire         opc_def   = defined_op(opc_q);
    wire cpu8d_mode_t opc_mode = opc_def ? mode_of(opc_q) : implied_mode;
    wire [1:0]   opc_need  = nbytes(opc_mode);
    wire         is_wait   = (opc_q == CPU8D_OPC_WAIT);
    wire         is_stop   = (opc_q == CPU8D_OPC_STOP);
    wire         is_x2a    = (opc_q == CPU8D_OPC_X2A);
    wire         is_a2x    = (opc_q == CPU8D_OPC_A2X);
    wire [15:0]  x16       = {8'h00, idx_val};
    wire [15:0]  pair16    = {b1_q, b2_q};          // high byte first
    wire [7:0]   rel_byte  = (opc_mode == bit_branch_mode) ? b2_q : b1_q;
    wire [15:0]  rel_sx    = {{8{rel_byte[7]}}, rel_byte}; // signed
    wire         is_branch = (opc_mode == relative_mode) ||
                             (opc_mode == bit_branch_mode);
    wire         pin_wake  = !pin_s2_q;
    wire         wake      = irq_req || (stop_q && pin_wake);
    logic [15:0] ea;

    // operand address per mode
    always_comb begin
        case (opc_mode)
            direct_mode, bit_branch_mode:
                ea = {CPU8D_DPAGE_HI, b1_q};
            full_address_mode:
                ea = pair16;
            index_long_offset_mode:
                ea = 16'(pair16 + x16);
            index_short_offset_mode:
                ea = 16'({8'h00, b1_q} + x16);     // unsigned
            index_plain_mode:
                ea = x16;
            default:
                ea = 16'h0000;
        endcase
    end

    assign fetch_ready = (state_q == ST_OPC) || (state_q == ST_OP1) ||
                         (state_q == ST_OP2);

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OPC:  if (take) state_d = (in_need == 2'd0) ? ST_EXEC : ST_OP1;
            ST_OP1:  if (take) state_d = (opc_need == 2'd2) ? ST_OP2
                                                           : ST_EXEC;
            ST_OP2:  if (take) state_d = ST_EXEC; // second byte
            ST_EXEC: state_d = (is_wait || is_stop) ? ST_HALT : ST_OPC;
            ST_HALT: if (wake) state_d = ST_OPC;
            default: state_d = ST_OPC;
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer and operand capture
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_OPC;
            opc_q   <= 8'h00;
            b1_q    <= 8'h00;
            b2_q    <= 8'h00;
        end else begin
            state_q <= state_d;
            if (take && state_q == ST_OPC) opc_q <= fetch_byte;
            if (take && state_q == ST_OP1) b1_q  <= fetch_byte;
            if (take && state_q == ST_OP2) b2_q  <= fetch_byte;
        end
    end

    // pin passes two flops before the wake logic looks at it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= ext_irq_b;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // issue: everything lands one edge after the execute cycle
    // ------------------------------------------------------------------
    wire exec = (state_q == ST_EXEC);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dec_q       <= '0;
            dec_valid_q <= 1'b0;
            pc_load_q   <= 1'b0;
            acc_we_q    <= 1'b0;
            idx_we_q    <= 1'b0;
            wr_data_q   <= 8'h00;
        end else begin
            dec_valid_q <= exec;
            pc_load_q   <= exec && is_branch && br_cond;
            acc_we_q    <= exec && is_x2a;
            idx_we_q    <= exec && is_a2x;
            if (exec) begin
                wr_data_q            <= is_x2a ? idx_val : acc_val;
                dec_q.opcode         <= opc_q;
                dec_q.group          <= opc_q[7:4];
                dec_q.oper           <= opc_q[3:0];
                dec_q.mode           <= opc_mode;
                dec_q.ea             <= ea;
                dec_q.literal        <= b1_q;
                dec_q.br_target      <= 16'(pc_next + rel_sx);
                dec_q.undefined      <= !opc_def;
                dec_q.x_to_a         <= is_x2a;
                dec_q.a_to_x         <= is_a2x;
                dec_q.imask_clr      <= is_wait || is_stop;
                dec_q.flags_keep     <= is_x2a || is_a2x || is_wait ||
                                        is_stop || !opc_def;
            end
        end
    end

    // low-power state: wait gates cpu clock, stop also the oscillator
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_halt_q    <= 1'b0;
            osc_stop_q    <= 1'b0;
            pin_wake_en_q <= 1'b0;
            stop_q        <= 1'b0;
        end else if (exec && (is_wait || is_stop)) begin
            cpu_halt_q    <= 1'b1;
            osc_stop_q    <= is_stop;
            pin_wake_en_q <= is_stop;
            stop_q        <= is_stop;
        end else if (state_q == ST_HALT && wake) begin
            cpu_halt_q    <= 1'b0;
            osc_stop_q    <= 1'b0;
            pin_wake_en_q <= 1'b0;
            stop_q        <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_X2A_TWO_CYC: assert property (@(posedge core_clk) disable iff (!rst_b)
        (take && state_q == ST_OPC && fetch_byte == CPU8D_OPC_X2A)
        |-> ##2 (acc_we_q && dec_valid_q && wr_data_q == $past(idx_val)))
        else $error("index to acc not done in two cycles");
    AST_A2X_TWO_CYC: assert property (@(posedge core_clk) disable iff (!rst_b)
        (take && state_q == ST_OPC && fetch_byte == CPU8D_OPC_A2X)
        |-> ##2 (idx_we_q && dec_q.flags_keep))
        else $error("acc to index not done in two cycles");
    AST_WAIT_HALTS: assert property (@(posedge core_clk) disable iff (!rst_b)
        (take && state_q == ST_OPC && fetch_byte == CPU8D_OPC_WAIT)
        |-> ##2 (cpu_halt_q && !osc_stop_q && dec_q.imask_clr))
        else $error("wait did not halt with mask clear");
    AST_STOP_ARMS: assert property (@(posedge core_clk) disable iff (!rst_b)
        (take && state_q == ST_OPC && fetch_byte == CPU8D_OPC_STOP)
        |-> ##2 (osc_stop_q && pin_wake_en_q && dec_q.imask_clr))
        else $error("stop did not arm pin wake");
    AST_HALT_NO_FETCH: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_q == ST_HALT && !wake) |=> (!fetch_ready && cpu_halt_q))
        else $error("fetch while halted");
    AST_FULL_ADDR: assert property (@(posedge core_clk) disable iff (!rst_b)
        (dec_valid_q && dec_q.mode == full_address_mode)
        |-> dec_q.ea == {$past(b1_q), $past(b2_q)})
        else $error("extended address byte order");
    AST_LONG_OFS_ADDR: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (dec_valid_q && dec_q.mode == index_long_offset_mode)
        |-> dec_q.ea == 16'({$past(b1_q), $past(b2_q)} + $past(x16)))
        else $error("16-bit indexed address wrong");
    AST_SHORT_OFS_ADDR: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (dec_valid_q && dec_q.mode == index_short_offset_mode)
        |-> dec_q.ea == 16'({8'h00, $past(b1_q)} + $past(x16)))
        else $error("8-bit indexed address wrong");
    AST_PLAIN_NO_OPND: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (take && state_q == ST_OPC && fetch_byte[7:4] == 4'hF)
        |=> (state_q == ST_EXEC) ##1 (dec_q.ea == $past(x16)))
        else $error("plain indexed fetched operands");
    AST_BIT_BR_ORDER: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (take && state_q == ST_OPC && fetch_byte[7:4] == CPU8D_COL_BITBR)
        |=> (state_q == ST_OP1))
        else $error("bit branch operand sequence");
    AST_BR_TAKEN: assert property (@(posedge core_clk) disable iff (!rst_b)
        (exec && is_branch) |=> (pc_load_q == $past(br_cond)))
        else $error("branch load mismatch");
    AST_UNDEF_NOP: assert property (@(posedge core_clk) disable iff (!rst_b)
        (dec_valid_q && dec_q.undefined)
        |-> (!acc_we_q && !idx_we_q && !pc_load_q && !cpu_halt_q))
        else $error("undefined opcode had effect");

endmodule : cpu8d_decoder

/* File: common/cpu8d_pkg.sv */
// constants and carrier types for the 8-bit core opcode decoder
// assumes one core clock; no software-visible registers
package cpu8d_pkg;

    // ------------------------------------------------------------------
    // opcodes with their own sequencing
    // ------------------------------------------------------------------
    localparam logic [7:0] CPU8D_OPC_X2A  = 8'h9F; // index to accumulator
    localparam logic [7:0] CPU8D_OPC_A2X  = 8'h97; // accumulator to index
    localparam logic [7:0] CPU8D_OPC_WAIT = 8'h8F; // wait for interrupt
    localparam logic [7:0] CPU8D_OPC_STOP = 8'h8E; // stop oscillator
    localparam logic [7:0] CPU8D_OPC_BSR  = 8'hAD; // relative call in col A
    localparam logic [3:0] CPU8D_COL_BITBR = 4'h0; // bit test and branch
    localparam logic [3:0] CPU8D_COL_BITMN = 4'h1; // bit set / clear
    localparam logic [3:0] CPU8D_COL_REL   = 4'h2; // relative branches
    localparam logic [7:0] CPU8D_DPAGE_HI  = 8'h00; // direct page high byte
    localparam logic [1:0] CPU8D_IMPL_CYC  = 2'd2;  // implied op cycles

    // ------------------------------------------------------------------
    // addressing modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        implied_mode, literal_mode, direct_mode, full_address_mode,
        relative_mode, index_plain_mode, index_short_offset_mode,
        index_long_offset_mode, bit_branch_mode
    } cpu8d_mode_t;

    // decoded instruction handed to the datapath
    typedef struct packed {
        logic [7:0]  opcode;     // whole opcode byte
        logic [3:0]  group;      // high nibble: group and mode column
        logic [3:0]  oper;       // low nibble: operation in column
        cpu8d_mode_t mode;       // addressing mode
        logic [15:0] ea;         // operand address
        logic [7:0]  literal;    // immediate byte
        logic [15:0] br_target;  // relative branch target
        logic        undefined;  // blank slot, executed as no-op
        logic        x_to_a;     // xfer_index_to_acc
        logic        a_to_x;     // xfer_acc_to_index
        logic        imask_clr;  // clear interrupt mask in condition_flags
        logic        flags_keep; // condition_flags otherwise untouched
    } cpu8d_dec_t;

endpackage : cpu8d_pkg

/* File: sim/cpu8d_fetch_model.sv */
// fetch-side model: offers program bytes in order on valid/ready
// assumes the bench loads bytes through push_byte between clock edges
`timescale 1ns/10ps
module cpu8d_fetch_model
    import cpu8d_pkg::*;
(
    input  wire logic       core_clk,    // core clock
    input  wire logic       rst_b,       // async reset, active low
    input  wire logic       slow,        // random gaps between bytes
    input  wire logic       fetch_ready, // decoder takes byte
    output logic            fetch_valid, // byte offered
    output logic [7:0]      fetch_byte   // program byte
);
    logic [7:0] prog_q[$]; // bytes still to offer, program order

    // bench side loads program bytes, high operand byte first
    task automatic push_byte(input logic [7:0] b);
        prog_q.push_back(b);
    endtask : push_byte

    // ------------------------------------------------------------------
    // offer engine
    // ------------------------------------------------------------------
    // an offer holds until taken; idle data toggles so a stale byte
    // can never pass for a fresh one
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_valid <= 1'b0;
            fetch_byte  <= 8'h00;
        end else if (!fetch_valid || fetch_ready) begin
            if (prog_q.size() != 0 && !(slow && $urandom_range(1, 0) == 0))
            begin
                fetch_valid <= 1'b1;
                fetch_byte  <= prog_q.pop_front();
            end else begin
                fetch_valid <= 1'b0;
                fetch_byte  <= ~fetch_byte;
            end
        end
    end
endmodule : cpu8d_fetch_model

/* File: sim/cpu8_opcode_decoder_tb_top.sv */
// self-checking bench for the opcode decoder
// assumes the fetch model stands in for program memory; the bench
// plays the execution datapath and both interrupt sources
`timescale 1ns/10ps
module cpu8_opcode_decoder_tb_top
    import cpu8d_pkg::*;
;
    // expected issue: fl = {pin,imask,osc,halt,load,idx_we,acc_we,undef}
    typedef struct {
        logic [7:0]  opc; // opcode byte
        cpu8d_mode_t mode; // addressing mode
        logic [15:0] ea;  // operand address
        logic [15:0] tgt; // branch target
        logic [7:0]  lit; // literal byte
        logic [7:0]  wr;  // transfer data
        logic [7:0]  fl;  // flag outputs
    } cpu8d_note_t;

    localparam logic [7:0] T_OPC [18] = '{8'h9F, 8'h97, 8'hC6, 8'hD6,
        8'hE6, 8'hF6, 8'hB6, 8'hA6, 8'h27, 8'hAD, 8'h05, 8'h0F, 8'h14,
        8'h3C, 8'h4C, 8'h6C, 8'h7C, 8'h9D};
    localparam cpu8d_mode_t T_MODE [18] = '{implied_mode, implied_mode,
        full_address_mode, index_long_offset_mode, index_short_offset_mode,
        index_plain_mode, direct_mode, literal_mode, relative_mode,
        relative_mode, bit_branch_mode, bit_branch_mode, direct_mode,
        direct_mode, implied_mode, index_short_offset_mode,
        index_plain_mode, implied_mode};
    localparam logic [7:0] U_OPC [6] = '{8'h2E, 8'hA7, 8'hAC, 8'h82,
        8'h9E, 8'h31}; // blank map slots

    logic        core_clk, rst_b, slow;  // clock, reset, fetch gaps
    logic        fetch_valid, fetch_ready; // fetch handshake
    logic [7:0]  fetch_byte, idx_val, acc_val; // byte, datapath regs
    logic [15:0] pc_next;                // pc after instruction
    logic        br_cond, irq_req, ext_irq_b; // branch, wake sources
    cpu8d_dec_t  dec_q;                  // decoded instruction
    logic        dec_valid_q, pc_load_q, acc_we_q, idx_we_q; // pulses
    logic [7:0]  wr_data_q;              // transfer data
    logic        cpu_halt_q, osc_stop_q, pin_wake_en_q; // halt levels
    cpu8d_note_t note_q[$];              // expected issues, oldest first
    cpu8d_note_t e;                      // note under comparison
    int          bad_count, n_checks, cyc, take_cyc; // counters

    cpu8d_decoder u_cpu8d_decoder (.core_clk(core_clk), .rst_b(rst_b),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
        .fetch_ready(fetch_ready), .idx_val(idx_val), .acc_val(acc_val),
        .pc_next(pc_next), .br_cond(br_cond), .irq_req(irq_req),
        .ext_irq_b(ext_irq_b), .dec_q(dec_q), .dec_valid_q(dec_valid_q),
        .pc_load_q(pc_load_q), .acc_we_q(acc_we_q), .idx_we_q(idx_we_q),
        .wr_data_q(wr_data_q), .cpu_halt_q(cpu_halt_q),
        .osc_stop_q(osc_stop_q), .pin_wake_en_q(pin_wake_en_q));
    cpu8d_fetch_model u_fetch (.core_clk(core_clk), .rst_b(rst_b),
        .slow(slow), .fetch_ready(fetch_ready),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // notes the expectation, then hands opcode and operands to fetch
    task automatic issue(input logic [7:0] opc, input cpu8d_mode_t m,
                         input logic und);
        cpu8d_note_t n;
        logic [7:0]  b1, b2;
        b1 = 8'($urandom());
        b2 = 8'($urandom());
        n = '{opc, m, 16'h0000, 16'h0000, b1, 8'h00, {7'h00, und}};
        case (m)
            full_address_mode:       n.ea = {b1, b2};
            index_long_offset_mode:  n.ea = {b1, b2} + 16'(idx_val);
            index_short_offset_mode: n.ea = 16'(b1) + 16'(idx_val);
            index_plain_mode:        n.ea = 16'(idx_val);
            direct_mode:             n.ea = {CPU8D_DPAGE_HI, b1};
            bit_branch_mode:         n.ea = {CPU8D_DPAGE_HI, b1};
            default: ;
        endcase
        n.tgt = pc_next + ((m == bit_branch_mode) ?
                {{8{b2[7]}}, b2} : {{8{b1[7]}}, b1});
        n.fl[3] = (m inside {relative_mode, bit_branch_mode}) && br_cond;
        n.fl[1] = (opc == CPU8D_OPC_X2A);
        n.fl[2] = (opc == CPU8D_OPC_A2X);
        n.wr = (opc == CPU8D_OPC_X2A) ? idx_val : acc_val;
        n.fl[4] = (opc == CPU8D_OPC_WAIT) || (opc == CPU8D_OPC_STOP);
        n.fl[6] = n.fl[4];
        n.fl[5] = (opc == CPU8D_OPC_STOP);
        n.fl[7] = n.fl[5];
        note_q.push_back(n);
        u_fetch.push_byte(opc);
        if (!(m inside {implied_mode, index_plain_mode})) u_fetch.push_byte(b1);
        if (m inside {full_address_mode, index_long_offset_mode,
                      bit_branch_mode}) u_fetch.push_byte(b2);
    endtask : issue

    // waits, bounded, until every noted issue has appeared
    task automatic drain();
        for (int i = 0; i < 600 && note_q.size() != 0; i++)
            @(posedge core_clk);
        check(16'(note_q.size()), 16'h0000);
    endtask : drain

    // halt op, then wake by irq (0), by pin (1) or by reset (2)
    task automatic halt_run(input logic [7:0] opc, input int how);
        issue(opc, implied_mode, 1'b0);
        drain();
        @(posedge core_clk);
        ext_irq_b <= (how != 0); // pin low during wait must not wake
        repeat (6) @(posedge core_clk);
        #1 check(16'({cpu_halt_q, fetch_ready}), 16'h0002);
        @(posedge core_clk);
        irq_req   <= (how == 0);
        ext_irq_b <= (how != 1);
        rst_b     <= (how != 2);
        for (int i = 0; i < 8 && cpu_halt_q; i++) @(posedge core_clk);
        #1 check(16'({cpu_halt_q, osc_stop_q, pin_wake_en_q}), 16'h0000);
        check(16'(fetch_ready), 16'h0001);
        @(posedge core_clk);
        {irq_req, ext_irq_b, rst_b} <= 3'b011;
    endtask : halt_run

    // ------------------------------------------------------------------
    // clock, monitor and timeout
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // every issue is two edges after its last byte and matches a note
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            bad_count++;
            conclude();
        end
        if (rst_b && dec_valid_q) begin
            check(16'(cyc - take_cyc), 16'h0002);
            check(16'(note_q.size() != 0), 16'h0001);
            if (note_q.size() != 0) begin
                e = note_q.pop_front();
                check({dec_q.opcode, dec_q.group, dec_q.oper}, {e.opc, e.opc});
                check(16'(dec_q.mode), 16'(e.mode));
                check({pin_wake_en_q, dec_q.imask_clr, osc_stop_q,
                       cpu_halt_q, pc_load_q, idx_we_q, acc_we_q,
                       dec_q.undefined, 6'h00, dec_q.a_to_x,
                       dec_q.x_to_a}, {e.fl, 6'h00, e.fl[2:1]});
                if (e.fl[2:1] != 2'b00) check(16'(wr_data_q), 16'(e.wr));
                if (e.fl[2:1] != 2'b00 || e.fl[4]) check(16'(dec_q.flags_keep), 16'h0001);
                if (!(e.mode inside {implied_mode, literal_mode, relative_mode}))
                    check(dec_q.ea, e.ea);
                if (e.mode inside {relative_mode, bit_branch_mode})
                    check(dec_q.br_target, e.tgt);
                if (e.mode == literal_mode) check(16'(dec_q.literal), 16'(e.lit));
            end
        end
        if (fetch_valid && fetch_ready) take_cyc = cyc;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(47073));
        {bad_count, n_checks, cyc, take_cyc} = '0;
        {rst_b, slow, irq_req, br_cond, ext_irq_b} = 5'b00001;
        {idx_val, acc_val, pc_next} = 32'h0000_0000;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            @(posedge core_clk);
            slow    <= r[0];
            br_cond <= r[1];
            idx_val <= (r == 0) ? 8'hF0 : 8'($urandom()); // carry case
            acc_val <= 8'($urandom());
            pc_next <= 16'($urandom());
            @(posedge core_clk);
            foreach (T_OPC[t]) issue(T_OPC[t], T_MODE[t], 1'b0);
            foreach (U_OPC[u]) issue(U_OPC[u], implied_mode, 1'b1);
            drain();
            if (r < 3) halt_run((r == 0) ? CPU8D_OPC_WAIT : CPU8D_OPC_STOP, r);
        end
        conclude();
    end
endmodule : cpu8_opcode_decoder_tb_top
